//--- inc/isa_bus_pkg.sv
/*
 * Shared constants and types for the stackable bus cycle logic.
 * Assumes a single core clock at CORE_CLK_HZ.
 */
package isa_bus_pkg;
	localparam int CORE_CLK_HZ = 10_000_000;
	// bus clock range
	localparam int SYSCLK_MIN_KHZ = 2500;
	localparam int SYSCLK_MAX_KHZ = 25000;
	localparam int SYSCLK_REC_KHZ = 16000;
	localparam int SYSCLK_HALF_MAX = CORE_CLK_HZ / (2 * SYSCLK_MIN_KHZ * 1000);
	localparam int SYSCLK_HALF_RAW = CORE_CLK_HZ / (2 * SYSCLK_MAX_KHZ * 1000);
	localparam int SYSCLK_HALF_MIN = (SYSCLK_HALF_RAW < 1) ? 1 : SYSCLK_HALF_RAW;
	// reference oscillator, phase accumulator
	localparam longint OSC_HZ = 14_318_180;
	localparam int OSC_ACC_W = 24;
	localparam logic [OSC_ACC_W-1:0] OSC_INC =
		OSC_ACC_W'((OSC_HZ << OSC_ACC_W) / CORE_CLK_HZ);
	// bus reset hold
	localparam int RESET_HOLD_MS = 100;
	localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * (CORE_CLK_HZ / 1000);
	// command length in bus clocks after the address phase, minus one
	localparam logic [2:0] WAIT_16 = 3'h1;
	localparam logic [2:0] WAIT_8 = 3'h4;
	localparam int ALT_DLY = 2;
	localparam int IRQ_W = 11;
	localparam logic [3:0] LOW_MB_TOP = 4'h0;

	typedef enum logic [2:0] {
		CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR,
		CMD_DMA_RD, CMD_DMA_WR, CMD_REFRESH
	} cmd_type;

	typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_ALT} phase_type;
endpackage

//--- inc/clk_gen_if.sv
/*
 * Carrier between the bus clock generator and the cycle engine.
 * Assumes both ends run on the core clock.
 */
interface clk_gen_if;
	logic sysclk;
	logic sysclk_rise;
	logic osc;
	modport gen(output sysclk, output sysclk_rise, output osc);
	modport use_end(input sysclk, input sysclk_rise, input osc);
endinterface

//--- verilog/bus_clock_gen.sv
/*
 * Bus clock divider and reference oscillator phase accumulator.
 * Assumes the core clock; the oscillator aliases if CORE_CLK_HZ is below
 * twice the reference rate, so a real part runs this from a faster clock.
 */
module bus_clock_gen
	import isa_bus_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic sys_rst, // async reset, high
	input wire logic ce, // clock enable
	input wire logic [3:0] sysclk_half, // half period in core cycles
	clk_gen_if.gen cg // clocks to the engine
);
	typedef struct packed {
		logic [3:0] cnt;
		logic sysclk;
		logic rise;
		logic [OSC_ACC_W-1:0] acc;
	} cg_type;

	cg_type r, next_r;
	logic [3:0] half;

	always_comb begin
		next_r = r;
		// out-of-range settings are clamped to the reachable band
		if (sysclk_half < 4'(SYSCLK_HALF_MIN))
			half = 4'(SYSCLK_HALF_MIN);
		else if (sysclk_half > 4'(SYSCLK_HALF_MAX))
			half = 4'(SYSCLK_HALF_MAX);
		else
			half = sysclk_half;
		next_r.rise = 1'b0;
		if (r.cnt + 4'h1 >= half) begin
			next_r.cnt = 4'h0;
			next_r.sysclk = ~r.sysclk;
			next_r.rise = ~r.sysclk;
		end else begin
			next_r.cnt = r.cnt + 4'h1;
		end
		next_r.acc = r.acc + OSC_INC;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			r <= '0;
		else if (ce)
			r <= next_r;
	end

	assign cg.sysclk = r.sysclk;
	assign cg.sysclk_rise = r.rise;
	assign cg.osc = r.acc[OSC_ACC_W-1];

	AST_SYSCLK_TOGGLE: assert property (@(posedge core_clk) disable iff (sys_rst)
		(ce && r.rise) |-> r.sysclk)
		else $error("bus clock edge without high level");
endmodule

//--- verilog/isa_bus_master.sv
/*
 * Permanent master cycle engine for the stackable 16-bit expansion bus.
 * Assumes all bus inputs synchronous to core_clk, open-collector lines
 * resolved outside, and a pull-up on every released command strobe.
 */
// Notes on behaviour
// - BALE high while address valid; targets latch on its falling edge.
// - BALE held high throughout DMA, refresh and alternate master cycles.
// - IOR#/IOW# mark I/O reads and writes; targets decode SA[15:0] and AEN.
// - SMEMR#/SMEMW# only for the first megabyte; targets decode SA[19:0].
// - alternate master read strobe produces a delayed low-megabyte read.
// - memory strobes read inactive while bus ownership changes hands.
// - 0WS# ends a memory cycle early; ignored during DMA.
// - IOCHRDY low stretches the cycle until it returns high.
// - IOCHRDY low wins over 0WS#.
// - IOCHCK# low raises a non-maskable interrupt.
// - bus clock selectable, 2.5 to 25 MHz; above 16 MHz discouraged; the 10 MHz core clock gives 2.5 or 5 MHz here.
// - all bus cycle timing derives from SYSCLK; here the BALE rise and the alternate read delay follow the core clock.
// - free-running 14.31818 MHz reference, 50 percent duty; here aliased by the 10 MHz core clock.
// - RESETDRV high at least 100 ms after power-up and watchdog expiry.
// - interrupt lines active high; unused inputs must be masked.
// - SBHE# with SA0 selects word, upper byte or lower byte transfer.
module isa_bus_master
	import isa_bus_pkg::*;
#(
	parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
)(
	input wire logic core_clk, // core clock
	input wire logic sys_rst, // async reset, high
	input wire logic ce, // clock enable, freezes state
	input wire logic [3:0] sysclk_half, // bus clock half period setting
	input wire logic wdog_timeout, // watchdog expiry pulse
	input wire logic req_valid, // cycle request
	output logic req_ready, // engine idle and able
	input wire cmd_type req_cmd, // kind of cycle
	input wire logic [23:0] req_addr, // byte address
	input wire logic req_word, // 16-bit transfer
	input wire logic [15:0] req_wdata, // write data
	input wire logic [2:0] req_chan, // DMA channel
	output logic resp_valid, // cycle finished pulse
	output logic [15:0] resp_rdata, // read data
	output logic sysclk, // bus clock
	output logic osc, // reference oscillator
	output logic resetdrv, // bus reset
	output logic bale, // address latch enable
	output logic [19:0] sa, // system address
	output logic [23:17] la, // latched upper address
	output logic sbhe_n, // upper byte enable
	output logic aen, // DMA address enable
	output logic refresh_n, // refresh cycle
	output logic [7:0] dack_n, // DMA acknowledges
	output logic ior_n, // I/O read
	output logic iow_n, // I/O write
	output logic memr_n, // memory read
	output logic memw_n, // memory write
	output logic smemr_n, // low megabyte memory read
	output logic smemw_n, // low megabyte memory write
	output logic cmd_oe_n, // low while strobes and address driven
	output logic [15:0] sd_out, // data out
	output logic sd_oe_n, // low while data driven
	input wire logic [15:0] sd_in, // data in
	input wire logic iochrdy, // ready, low stretches
	input wire logic zws_n, // zero wait state request
	input wire logic iocs16_n, // 16-bit I/O target
	input wire logic memcs16_n, // 16-bit memory target
	input wire logic iochck_n, // fatal bus error
	output logic nmi, // non-maskable interrupt
	input wire logic alt_master, // alternate master owns bus
	input wire logic alt_memr_n, // alternate master read strobe
	input wire logic [3:0] alt_la_top, // alternate master LA[23:20]
	input wire logic [IRQ_W-1:0] irq_in, // interrupt lines
	input wire logic [IRQ_W-1:0] irq_enable, // used lines
	output logic [IRQ_W-1:0] irq_out // qualified interrupts
);
	// active-high strobe set {ior, iow, memr, memw}
	function automatic logic [3:0] strobes(input cmd_type c);
		case (c)
			CMD_IO_RD, CMD_DMA_RD: strobes = 4'h8;
			CMD_IO_WR, CMD_DMA_WR: strobes = 4'h4;
			CMD_MEM_RD, CMD_REFRESH: strobes = 4'h2;
			CMD_MEM_WR: strobes = 4'h1;
			default: strobes = 4'h0;
		endcase
	endfunction

	typedef struct packed {
		phase_type phase;
		cmd_type cmd;
		logic [23:0] addr;
		logic sbhe_n;
		logic [15:0] wdata;
		logic sd_oe_n;
		logic [2:0] wcnt;
		logic bale;
		logic aen;
		logic refresh_n;
		logic [7:0] dack_n;
		logic [3:0] strb_n;
		logic smemr_n;
		logic smemw_n;
		logic oe_n;
		logic [15:0] rdata;
		logic resp;
		logic ready;
		logic [ALT_DLY-1:0] alt_dly;
		logic [31:0] rst_cnt;
		logic resetdrv;
		logic nmi;
		logic [IRQ_W-1:0] irq;
	} st_type;

	st_type r, next_r;
	clk_gen_if cg();
	logic dma, hold_bale, low_mb, cs16, mem_cmd;
	logic [3:0] stb;

	bus_clock_gen u_clk (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.sysclk_half(sysclk_half),
		.cg(cg)
	);

	always_comb begin
		next_r = r;
		next_r.resp = 1'b0;
		dma = (r.cmd == CMD_DMA_RD) || (r.cmd == CMD_DMA_WR);
		hold_bale = dma || (r.cmd == CMD_REFRESH);
		low_mb = (r.addr[23:20] == LOW_MB_TOP);
		mem_cmd = (r.cmd == CMD_MEM_RD) || (r.cmd == CMD_MEM_WR);
		stb = strobes(r.cmd);
		cs16 = mem_cmd ? ~memcs16_n : ~iocs16_n;
		next_r.irq = irq_in & irq_enable;
		next_r.nmi = ~iochck_n;
		next_r.alt_dly = {r.alt_dly[ALT_DLY-2:0],
			~alt_memr_n & (alt_la_top == LOW_MB_TOP)};
		// counter restarts on a watchdog pulse; bus cycles requested after the pulse wait meanwhile
		if (wdog_timeout) begin
			next_r.rst_cnt = '0;
			next_r.resetdrv = 1'b1;
		end else if (r.rst_cnt < 32'(HOLD_CYCLES)) begin
			next_r.rst_cnt = r.rst_cnt + 32'h1;
		end else begin
			next_r.resetdrv = 1'b0;
		end
		case (r.phase)
			ST_IDLE: begin
				if (alt_master) begin
					next_r.phase = ST_ALT;
					next_r.bale = 1'b1;
					next_r.oe_n = 1'b1;
				end else if (req_valid && r.ready) begin
					next_r.phase = ST_ADDR;
					next_r.cmd = req_cmd;
					next_r.addr = req_addr;
					next_r.wdata = req_wdata;
					next_r.sbhe_n = ~(req_word | req_addr[0]);
					next_r.bale = 1'b1;
					if (req_cmd == CMD_DMA_RD || req_cmd == CMD_DMA_WR) begin
						next_r.aen = 1'b1;
						next_r.dack_n = ~(8'h01 << req_chan);
					end
					next_r.refresh_n = (req_cmd != CMD_REFRESH);
				end
			end
			ST_ADDR: begin
				if (cg.sysclk_rise) begin
					next_r.phase = ST_CMD;
					next_r.bale = hold_bale;
					next_r.strb_n = ~stb;
					next_r.smemr_n = ~(stb[1] & low_mb);
					next_r.smemw_n = ~(stb[0] & low_mb);
					next_r.sd_oe_n = ~(r.cmd == CMD_IO_WR ||
						r.cmd == CMD_MEM_WR);
					next_r.wcnt = cs16 ? WAIT_16 : WAIT_8;
				end
			end
			ST_CMD: begin
				// a stretched cycle outranks an early end request
				if (cg.sysclk_rise && iochrdy) begin
					if ((mem_cmd && !zws_n) || r.wcnt == 3'h0) begin
						next_r.phase = ST_IDLE;
						next_r.strb_n = 4'hF;
						next_r.smemr_n = 1'b1;
						next_r.smemw_n = 1'b1;
						next_r.sd_oe_n = 1'b1;
						next_r.bale = 1'b0;
						next_r.aen = 1'b0;
						next_r.dack_n = 8'hFF;
						next_r.refresh_n = 1'b1;
						next_r.rdata = sd_in;
						next_r.resp = 1'b1;
					end else begin
						next_r.wcnt = r.wcnt - 3'h1;
					end
				end
			end
			ST_ALT: begin
				next_r.smemr_n = ~r.alt_dly[ALT_DLY-1];
				if (!alt_master) begin
					next_r.phase = ST_IDLE;
					next_r.bale = 1'b0;
					next_r.oe_n = 1'b0;
					next_r.smemr_n = 1'b1;
				end
			end
			default: next_r.phase = ST_IDLE;
		endcase
		next_r.ready = (next_r.phase == ST_IDLE) && !next_r.resetdrv &&
			!alt_master;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
			r.phase <= ST_IDLE;
			r.cmd <= CMD_IO_RD;
			r.sbhe_n <= 1'b1;
			r.sd_oe_n <= 1'b1;
			r.refresh_n <= 1'b1;
			r.dack_n <= 8'hFF;
			r.strb_n <= 4'hF;
			r.smemr_n <= 1'b1;
			r.smemw_n <= 1'b1;
			r.resetdrv <= 1'b1;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign req_ready = r.ready;
	assign resp_valid = r.resp;
	assign resp_rdata = r.rdata;
	assign sysclk = cg.sysclk;
	assign osc = cg.osc;
	assign resetdrv = r.resetdrv;
	assign bale = r.bale;
	assign sa = r.addr[19:0];
	assign la = r.addr[23:17];
	assign sbhe_n = r.sbhe_n;
	assign aen = r.aen;
	assign refresh_n = r.refresh_n;
	assign dack_n = r.dack_n;
	assign {ior_n, iow_n, memr_n, memw_n} = r.strb_n;
	assign smemr_n = r.smemr_n;
	assign smemw_n = r.smemw_n;
	assign cmd_oe_n = r.oe_n;
	assign sd_out = r.wdata;
	assign sd_oe_n = r.sd_oe_n;
	assign nmi = r.nmi;
	assign irq_out = r.irq;

	sequence s_step;
		ce && cg.sysclk_rise;
	endsequence
	sequence s_stretch;
		r.phase == ST_CMD && !iochrdy;
	endsequence

	AST_BALE_LATCH: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(bale) |-> $stable(sa) && $stable(la))
		else $error("address moved as bale fell");
	AST_BALE_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
		(r.phase == ST_CMD && (aen || !refresh_n)) |-> bale)
		else $error("bale dropped in dma or refresh");
	AST_LOW_MB: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!smemr_n && r.phase == ST_CMD) |-> la[23:20] == 4'h0)
		else $error("low megabyte strobe above one megabyte");
	AST_ALT_READ: assert property (@(posedge core_clk) disable iff (sys_rst)
		(ce && r.phase == ST_ALT && alt_master && r.alt_dly[ALT_DLY-1])
		|=> !smemr_n)
		else $error("alternate read not mirrored");
	AST_RELEASE: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmd_oe_n |-> memr_n && memw_n && ior_n && iow_n)
		else $error("strobe active while released");
	AST_WAIT: assert property (@(posedge core_clk) disable iff (sys_rst)
		(s_stretch and s_step) |=> r.phase == ST_CMD)
		else $error("cycle ended while not ready");
	AST_DMA_NO_ZWS: assert property (@(posedge core_clk) disable iff (sys_rst)
		(r.phase == ST_CMD && aen && r.wcnt != 3'h0 && iochrdy and s_step)
		|=> r.phase == ST_CMD)
		else $error("dma cycle ended early");
	AST_NMI: assert property (@(posedge core_clk) disable iff (sys_rst)
		(ce && !iochck_n) |=> nmi)
		else $error("bus error without nmi");
	AST_RESET_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
		!resetdrv |-> r.rst_cnt >= 32'(HOLD_CYCLES))
		else $error("bus reset released early");
	AST_IRQ_MASK: assert property (@(posedge core_clk) disable iff (sys_rst)
		ce |=> (irq_out & ~$past(irq_enable)) == '0)
		else $error("masked interrupt passed");
	AST_ONE_STROBE: assert property (@(posedge core_clk) disable iff (sys_rst)
		$onehot0(~r.strb_n))
		else $error("more than one command strobe");
endmodule

//--- dv/isa_adapter_model.sv
/*
 * Behavioural plug-in adapter facing the stackable bus master.
 * Assumes strobes and address from the master, all on the core clock;
 * the bench sets wait states, zero-wait behaviour and read data.
 */
module isa_adapter_model (
	input wire logic core_clk, // core clock
	input wire logic resetdrv, // bus reset
	input wire logic aen, // DMA address enable
	input wire logic [19:0] sa, // system address
	input wire logic [23:17] la, // latched upper address
	input wire logic ior_n, // I/O read
	input wire logic iow_n, // I/O write
	input wire logic memr_n, // memory read
	input wire logic memw_n, // memory write
	input wire logic [3:0] wt, // wait states per cycle
	input wire logic use16, // answer as a 16-bit board
	input wire logic [1:0] zws_mode, // 0 off, 1 gated, 2 stuck low
	input wire logic [15:0] rdata, // read data
	output logic [15:0] sd_in, // data to master
	output logic iochrdy, // ready, low stretches
	output logic zws_n, // zero wait request
	output logic iocs16_n, // 16-bit I/O target
	output logic memcs16_n // 16-bit memory target
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	logic [15:0] last;
	logic pst;
	wire logic st = ~(ior_n & iow_n & memr_n & memw_n);

	always_ff @(posedge core_clk) begin
		last <= resetdrv ? 16'h0000 : sd_in;
		pst <= st;
		if (resetdrv) begin
			cnt <= 4'h0;
		end else if (st && !pst) begin
			cnt <= wt;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end

	// released lines flip every cycle outside bus reset so a late sample cannot match
	assign sd_in = (!resetdrv && !(ior_n & memr_n)) ? rdata : ~last;
	assign iochrdy = !(st && (pst ? cnt != 4'h0 : wt != 4'h0));
	assign iocs16_n = !(use16 && !aen && sa[15:4] == 12'h031);
	assign memcs16_n = !(use16 && la == 7'h08);
	// mode 2 breaks the strobe gating on purpose and holds zws_n low in every cycle
	assign zws_n = !(zws_mode == 2'h2 ||
		(zws_mode == 2'h1 && !(memr_n & memw_n)));
endmodule

//--- dv/stackable_isa_bus_cycle_logic_tb.sv
/*
 * Self-checking bench for the permanent master cycle engine.
 * Assumes the adapter model on the bus side and a 10 MHz core clock.
 */
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("unexpected at %0t: got %0h want %0h", $time, g, e); \
	end \
end

module stackable_isa_bus_cycle_logic_tb import isa_bus_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HOLD = 20;
	localparam int LIMIT = 5000;
	localparam logic [15:0] RD = 16'h5a3c;
	int tests_run = 0, miscompares = 0, cyc = 0, l8 = 0;
	int scnt, blo, multi, smr, smw, badrel;
	logic core_clk = 1'b0, sys_rst = 1'b1, wdog_timeout = 1'b0;
	logic req_valid = 1'b0, req_word = 1'b0, alt_master = 1'b0;
	logic alt_memr_n = 1'b1, iochck_n = 1'b1, pst = 1'b0, prdy = 1'b1;
	cmd_type req_cmd = CMD_IO_RD;
	logic [23:0] req_addr = 24'h00_0000;
	logic [15:0] req_wdata = 16'h0000, sd_out, sd_in, resp_rdata, sn_sd;
	logic [2:0] req_chan = 3'h0;
	logic [3:0] alt_la_top = 4'h0, wt = 4'h0, sn_str;
	logic [1:0] zws_mode = 2'h0;
	logic [IRQ_W-1:0] irq_in = '0, irq_enable = '0, irq_out;
	logic req_ready, resp_valid, sysclk, osc, resetdrv, bale, sbhe_n, aen;
	logic refresh_n, ior_n, iow_n, memr_n, memw_n, smemr_n, smemw_n;
	logic cmd_oe_n, sd_oe_n, iochrdy, zws_n, iocs16_n, memcs16_n, nmi;
	logic sn_aen, sn_ref, sn_oe;
	logic [19:0] sa;
	logic [23:17] la;
	logic [7:0] dack_n, sn_dack;
	wire logic st = ~(ior_n & iow_n & memr_n & memw_n);

	isa_bus_master #(.HOLD_CYCLES(HOLD)) i_dut (
		.core_clk, .sys_rst, .ce(1'b1), .sysclk_half(4'h1), .wdog_timeout,
		.req_valid, .req_ready, .req_cmd, .req_addr, .req_word, .req_wdata,
		.req_chan, .resp_valid, .resp_rdata, .sysclk, .osc, .resetdrv,
		.bale, .sa, .la, .sbhe_n, .aen, .refresh_n, .dack_n, .ior_n, .iow_n,
		.memr_n, .memw_n, .smemr_n, .smemw_n, .cmd_oe_n, .sd_out, .sd_oe_n,
		.sd_in, .iochrdy, .zws_n, .iocs16_n, .memcs16_n, .iochck_n, .nmi,
		.alt_master, .alt_memr_n, .alt_la_top, .irq_in, .irq_enable,
		.irq_out);
	isa_adapter_model i_adapter (.core_clk, .resetdrv, .aen, .sa, .la,
		.ior_n, .iow_n, .memr_n, .memw_n, .wt, .use16(1'b1), .zws_mode,
		.rdata(RD), .sd_in, .iochrdy, .zws_n, .iocs16_n, .memcs16_n);

	always #50 core_clk = ~core_clk;

	// sampled on the falling edge so the counts are settled for the main flow
	always @(negedge core_clk) begin
		cyc++;
		if (st) begin
			scnt++;
			blo += int'(!bale);
			multi += int'($countones({ior_n, iow_n, memr_n, memw_n}) < 3);
			smr += int'(!smemr_n);
			smw += int'(!smemw_n);
			sn_str = {ior_n, iow_n, memr_n, memw_n};
			sn_aen = aen;
			sn_dack = dack_n;
			sn_ref = refresh_n;
			sn_sd = sd_out;
			sn_oe = sd_oe_n;
		end
		if (pst && !st && !prdy)
			badrel++;
		pst = st;
		prdy = iochrdy;
		if (cyc == LIMIT) begin
			miscompares++;
			end_sim();
		end
	end

	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic run(input cmd_type c, input logic [23:0] a,
			input logic w, input logic [2:0] ch);
		int n;
		scnt = 0;
		blo = 0;
		multi = 0;
		smr = 0;
		smw = 0;
		badrel = 0;
		req_cmd <= c;
		req_addr <= a;
		req_word <= w;
		req_wdata <= a[15:0];
		req_chan <= ch;
		req_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 200);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (resp_valid !== 1'b1 && n < 200);
		`CHK(resp_valid, 1'b1)
		`CHK(multi, 0)
		`CHK(badrel, 0)
		`CHK({sbhe_n, sa, la}, {~(w | a[0]), a[19:0], a[23:17]})
	endtask

	task hold_chk;
		int n;
		n = 0;
		while (resetdrv === 1'b1 && n < 500) begin
			`CHK({st, req_ready}, 2'b00)
			n++;
			@(posedge core_clk);
		end
		`CHK(n >= HOLD, 1'b1)
		$display("bus reset hold test done");
	endtask

	task t_io;
		run(CMD_IO_RD, 24'h00_0301, 1'b0, 3'h0);
		`CHK(resp_rdata, RD)
		`CHK(blo, scnt)
		`CHK(sn_aen, 1'b0)
		l8 = scnt;
		run(CMD_IO_WR, 24'h00_0310, 1'b1, 3'h0);
		`CHK({sn_str, sn_sd, sn_oe}, {4'hb, 16'h0310, 1'b0})
		`CHK(scnt, l8 - 2 * int'(WAIT_8 - WAIT_16))
		run(CMD_IO_RD, 24'h00_0312, 1'b0, 3'h0);
		$display("io cycle test done");
	endtask

	task t_mem;
		run(CMD_MEM_WR, 24'h0c_8000, 1'b0, 3'h0);
		`CHK({sn_str, sn_sd}, {4'he, 16'h8000})
		`CHK(smw > 0, 1'b1)
		run(CMD_MEM_RD, 24'h10_0000, 1'b1, 3'h0);
		`CHK(resp_rdata, RD)
		`CHK(smr, 0)
		`CHK(scnt, l8 - 2 * int'(WAIT_8 - WAIT_16))
		$display("memory cycle test done");
	endtask

	task t_wait;
		wt <= 4'h3;
		run(CMD_MEM_RD, 24'h0c_0000, 1'b0, 3'h0);
		`CHK(scnt > l8, 1'b1)
		zws_mode <= 2'h1;
		run(CMD_MEM_RD, 24'h0c_0000, 1'b0, 3'h0);
		`CHK(scnt > 2, 1'b1)
		wt <= 4'h0;
		run(CMD_MEM_RD, 24'h0c_0000, 1'b0, 3'h0);
		`CHK(scnt, 2)
		zws_mode <= 2'h2;
		run(CMD_DMA_RD, 24'h00_0310, 1'b0, 3'h2);
		`CHK(scnt, l8)
		zws_mode <= 2'h0;
		$display("wait state test done");
	endtask

	task dma_chk(input cmd_type c, input logic [2:0] ch,
			input logic [3:0] s, input logic dma);
		run(c, 24'h00_0040, 1'b0, ch);
		`CHK(blo, 0)
		`CHK(sn_str, s)
		`CHK(sn_ref, dma)
		if (dma)
			`CHK({sn_aen, sn_dack}, {1'b1, ~(8'h01 << ch)})
	endtask

	task t_dma;
		dma_chk(CMD_DMA_RD, 3'h1, 4'h7, 1'b1);
		dma_chk(CMD_DMA_WR, 3'h5, 4'hb, 1'b1);
		dma_chk(CMD_REFRESH, 3'h0, 4'hd, 1'b0);
		$display("dma and refresh test done");
	endtask

	task t_irq;
		logic pc, po;
		int tg;
		pc = sysclk;
		po = osc;
		tg = 0;
		// half period setting of one core cycle: bus clock flips every edge
		repeat (8) begin
			@(posedge core_clk);
			`CHK(sysclk, ~pc)
			tg += int'(osc != po);
			pc = sysclk;
			po = osc;
		end
		`CHK(tg > 2, 1'b1)
		iochck_n <= 1'b0;
		irq_in <= '1;
		irq_enable <= 11'h0f0;
		repeat (2) @(posedge core_clk);
		`CHK({nmi, irq_out}, {1'b1, 11'h0f0})
		iochck_n <= 1'b1;
		irq_in <= 11'h50a;
		repeat (2) @(posedge core_clk);
		`CHK({nmi, irq_out}, {1'b0, 11'h000})
		$display("interrupt test done");
	endtask

	task t_alt;
		int n;
		alt_master <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK({cmd_oe_n, bale, req_ready}, 3'h6)
		alt_memr_n <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (smemr_n !== 1'b0 && n < 8);
		`CHK(n inside {[3:4]}, 1'b1)
		alt_la_top <= 4'h1;
		repeat (6) @(posedge core_clk);
		`CHK(smemr_n, 1'b1)
		alt_memr_n <= 1'b1;
		alt_master <= 1'b0;
		alt_la_top <= 4'h0;
		$display("alternate master test done");
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		`CHK({ior_n, iow_n, memr_n, memw_n, smemr_n, smemw_n}, 6'h3f)
		sys_rst <= 1'b0;
		hold_chk();
		t_io();
		t_mem();
		t_wait();
		t_dma();
		t_irq();
		t_alt();
		run(CMD_IO_WR, 24'h00_0302, 1'b0, 3'h0);
		wdog_timeout <= 1'b1;
		@(posedge core_clk);
		wdog_timeout <= 1'b0;
		@(posedge core_clk);
		`CHK(resetdrv, 1'b1)
		hold_chk();
		end_sim();
	end
endmodule
